// file: spa_defs.vh
// Constants shared by the serial packet accumulator files
`ifndef SPA_DEFS_VH
`define SPA_DEFS_VH

// ==========================================================
// Buffer geometry
`define SPA_BUF_BYTES 11'h400
`define SPA_ADDR_W 10
`define SPA_CNT_W 11

// ==========================================================
// Post-delimiter process codes
`define SPA_PROC_NONE 2'h0
`define SPA_PROC_PLUS1 2'h1
`define SPA_PROC_PLUS2 2'h2
`define SPA_PROC_STRIP 2'h3

// ==========================================================
// Reset values
`define SPA_CNT_RST 11'h000
`define SPA_POST_RST 2'h0
`define SPA_BYTE_RST 8'h00

// ==========================================================
// Time base
`define SPA_CLK_NS 10
`define SPA_MS_NS 1000000
`define SPA_PRE_W 17
`define SPA_MS_W 17

`endif

// file: spa_skid.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps

module spa_skid #(
  parameter W = 9 // Entry width
) (
  input wire ref_clk_i, // System clock
  input wire rst_b_i, // Asynchronous reset, active low
  input wire in_valid_i, // Entry offered
  output wire in_ready_o, // Room for an entry
  input wire [W-1:0] in_data_i, // Entry offered
  output wire out_valid_o, // Entry available
  input wire out_ready_i, // Receiver takes entry
  output wire [W-1:0] out_data_o // Oldest entry
);

  reg [W-1:0] ent_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] fill_q;
  wire push;
  wire pop;

  // ==========================================================
  // Flags: full stalls the source so no word is lost
  assign in_ready_o = (fill_q != 2'h2);
  assign out_valid_o = (fill_q != 2'h0);
  assign out_data_o = ent_q[rp_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Entry storage, no reset needed on data
  always @(posedge ref_clk_i)
  begin
    if (push)
      ent_q[wp_q] <= in_data_i;
  end

  // Pointers and fill level
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      fill_q <= 2'h0;
    end
    else
    begin
      if (push)
        wp_q <= ~wp_q;
      if (pop)
        rp_q <= ~rp_q;
      if (push && !pop)
        fill_q <= fill_q + 2'h1;
      else if (pop && !push)
        fill_q <= fill_q - 2'h1;
    end
  end

endmodule // spa_skid

// file: spa_accum.v
// Serial packet accumulator: byte buffer and packet release triggers
//
// Function
// - Length zero: release only on delimiter, full buffer or idle gap.
// - Nonzero length: release when byte count equals programmed length.
// - First delimiter: matching byte releases the buffer, then empties it.
// - Both delimiters: process starts only after both characters arrive.
// - Full buffer releases a packet even with delimiters enabled.
// - Post-delimiter process applies only with first delimiter enabled.
// - No-action process releases at once, delimiter included.
// - Plus-one process waits one further byte, then releases.
// - Plus-two process waits two further bytes, then releases.
// - Strip process removes delimiter characters before release.
// - Gap time zero disables the idle timer.
// - Silence longer than gap milliseconds releases buffered bytes.
// - Bytes are held until full or a release trigger fires.
// - One kilobyte accumulation buffer per serial port.
// - Link-down low option drives RTS and DTR low when disconnected.
`timescale 1ns/1ps
`include "spa_defs.vh"

module spa_accum #(
  parameter MS_CYCLES = `SPA_MS_NS / `SPA_CLK_NS // Cycles per millisecond
) (
  input wire ref_clk_i, // System clock, 100 MHz
  input wire rst_b_i, // Asynchronous reset, active low
  input wire rx_valid_i, // Serial byte offered
  output wire rx_ready_o, // Serial byte taken
  input wire [7:0] rx_data_i, // Serial byte
  output wire tx_valid_o, // Packet byte available
  input wire tx_ready_i, // Network takes packet byte
  output wire [7:0] tx_data_o, // Packet byte
  output wire tx_last_o, // Final byte of packet
  input wire [10:0] pkt_len_i, // Packet length, zero for none
  input wire delim1_en_i, // First delimiter enable
  input wire [7:0] delim1_i, // First delimiter byte
  input wire delim2_en_i, // Second delimiter enable
  input wire [7:0] delim2_i, // Second delimiter byte
  input wire [1:0] delim_proc_i, // Post-delimiter process
  input wire [15:0] gap_ms_i, // Idle gap in ms, zero off
  input wire link_down_low_i, // Drive modem lines low on link loss
  input wire link_up_i, // Network link is up
  input wire rts_req_i, // Requested RTS level
  input wire dtr_req_i, // Requested DTR level
  output wire rts_o, // RTS modem output
  output wire dtr_o, // DTR modem output
  output wire busy_o // Packet being drained
);

  localparam ST_ACCUM = 1'b0;
  localparam ST_DRAIN = 1'b1;
  localparam integer PRE_ALL = MS_CYCLES - 1;
  localparam [`SPA_PRE_W-1:0] PRE_LAST = PRE_ALL[`SPA_PRE_W-1:0];

  // ==========================================================
  // Storage and state
  // one kilobyte buffer
  reg [7:0] mem [0:1023];
  reg state_q;
  reg state_d;
  reg [`SPA_CNT_W-1:0] cnt_q;
  reg [`SPA_CNT_W-1:0] cnt_d;
  reg [`SPA_CNT_W-1:0] len_q;
  reg [`SPA_CNT_W-1:0] len_d;
  reg [`SPA_ADDR_W-1:0] rd_q;
  reg [`SPA_ADDR_W-1:0] rd_d;
  reg [1:0] post_q;
  reg [1:0] post_d;
  reg prev_d1_q;
  reg prev_d1_d;
  reg [`SPA_CNT_W-1:0] drop;
  reg rel;
  reg restart;
  reg [`SPA_PRE_W-1:0] pre_q;
  reg [`SPA_MS_W-1:0] ms_q;
  reg rts_q;
  reg dtr_q;

  wire acc;
  wire [`SPA_CNT_W-1:0] cnt_inc;
  wire delim_on;
  wire two_on;
  wire hit;
  wire gap_hit;
  wire push_rdy;
  wire push_last;
  wire [8:0] skid_out;

  // ==========================================================
  // Input side handshake
  // bytes are only taken while accumulating
  assign rx_ready_o = (state_q == ST_ACCUM);
  assign acc = rx_valid_i && rx_ready_o;
  assign cnt_inc = cnt_q + 11'h001;
  assign busy_o = (state_q == ST_DRAIN);

  // Delimiter enables; a lone second delimiter is ignored
  // delimiters live only with no length limit
  // process runs only with first delimiter on
  assign delim_on = delim1_en_i && (pkt_len_i == 11'h000);
  assign two_on = delim_on && delim2_en_i;

  // Delimiter condition on the incoming byte
  // compare with first delimiter, or with second after the first when both on
  assign hit = delim_on &&
    (two_on ? (prev_d1_q && (rx_data_i == delim2_i)) :
    (rx_data_i == delim1_i));

  // Idle gap: strictly more milliseconds than programmed
  // zero turns the timer off
  assign gap_hit = (gap_ms_i != 16'h0000) && (cnt_q != 11'h000) &&
    (ms_q > {1'b0, gap_ms_i});

  // ==========================================================
  // Byte store; write address is the running count
  always @(posedge ref_clk_i)
  begin
    if (acc && (cnt_q != `SPA_BUF_BYTES))
      mem[cnt_q[`SPA_ADDR_W-1:0]] <= rx_data_i;
  end

  // ==========================================================
  // Release decision and drain sequencing
  always @*
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    len_d = len_q;
    rd_d = rd_q;
    post_d = post_q;
    prev_d1_d = prev_d1_q;
    drop = `SPA_CNT_RST;
    rel = 1'b0;
    restart = 1'b0;
    case (state_q)
      ST_ACCUM:
      begin
        if (acc)
        begin
          restart = 1'b1;
          cnt_d = cnt_inc;
          prev_d1_d = (rx_data_i == delim1_i);
          if (post_q != `SPA_POST_RST)
          begin
            if (post_q == 2'h1)
              rel = 1'b1;
            else
              post_d = post_q - 2'h1;
          end
          else if (hit)
          begin
            case (delim_proc_i)
              `SPA_PROC_NONE: rel = 1'b1;
              `SPA_PROC_PLUS1: post_d = 2'h1;
              `SPA_PROC_PLUS2: post_d = 2'h2;
              default:
              begin
                rel = 1'b1;
                drop = two_on ? 11'h002 : 11'h001;
              end
            endcase
          end
          // no limit when length is zero
          if ((pkt_len_i != 11'h000) && (cnt_inc == pkt_len_i))
            rel = 1'b1;
          if (cnt_inc == `SPA_BUF_BYTES)
            rel = 1'b1;
          if (rel)
          begin
            len_d = cnt_inc - drop;
            post_d = `SPA_POST_RST;
            prev_d1_d = 1'b0;
            rd_d = {`SPA_ADDR_W{1'b0}};
            if (len_d == `SPA_CNT_RST)
              cnt_d = `SPA_CNT_RST;
            else
              state_d = ST_DRAIN;
          end
        end
        else if (gap_hit)
        begin
          len_d = cnt_q;
          post_d = `SPA_POST_RST;
          prev_d1_d = 1'b0;
          rd_d = {`SPA_ADDR_W{1'b0}};
          restart = 1'b1;
          state_d = ST_DRAIN;
        end
      end
      default:
      begin
        // Drain stalls when the two-entry buffer is full
        if (push_rdy)
        begin
          rd_d = rd_q + 10'h001;
          if (push_last)
          begin
            cnt_d = `SPA_CNT_RST;
            state_d = ST_ACCUM;
          end
        end
      end
    endcase
  end

  // Control registers
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= ST_ACCUM;
      cnt_q <= `SPA_CNT_RST;
      len_q <= `SPA_CNT_RST;
      rd_q <= {`SPA_ADDR_W{1'b0}};
      post_q <= `SPA_POST_RST;
      prev_d1_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      len_q <= len_d;
      rd_q <= rd_d;
      post_q <= post_d;
      prev_d1_q <= prev_d1_d;
    end
  end

  // ==========================================================
  // Millisecond prescaler and silence counter
  // restart on every received byte
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pre_q <= {`SPA_PRE_W{1'b0}};
      ms_q <= {`SPA_MS_W{1'b0}};
    end
    else if (restart || (state_q == ST_DRAIN))
    begin
      pre_q <= {`SPA_PRE_W{1'b0}};
      ms_q <= {`SPA_MS_W{1'b0}};
    end
    else if (pre_q == PRE_LAST)
    begin
      pre_q <= {`SPA_PRE_W{1'b0}};
      // Saturate so a long silence cannot wrap to a small count
      if (ms_q != {`SPA_MS_W{1'b1}})
        ms_q <= ms_q + 17'h00001;
    end
    else
      pre_q <= pre_q + 17'h00001;
  end

  // ==========================================================
  // Output path through the two-entry buffer
  assign push_last = ({1'b0, rd_q} == (len_q - 11'h001));

  spa_skid #(
    .W(9)
  ) u_skid (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(state_q == ST_DRAIN),
    .in_ready_o(push_rdy),
    .in_data_i({push_last, mem[rd_q]}),
    .out_valid_o(tx_valid_o),
    .out_ready_i(tx_ready_i),
    .out_data_o(skid_out)
  );

  assign tx_data_o = skid_out[7:0];
  assign tx_last_o = skid_out[8];

  // ==========================================================
  // Modem control lines, registered
  // low on link loss when so configured
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rts_q <= 1'b0;
      dtr_q <= 1'b0;
    end
    else
    begin
      rts_q <= rts_req_i && !(link_down_low_i && !link_up_i);
      dtr_q <= dtr_req_i && !(link_down_low_i && !link_up_i);
    end
  end

  assign rts_o = rts_q;
  assign dtr_o = dtr_q;

endmodule // spa_accum

// file: spa_accum_asserts.sv
// Port-level checks of the serial packet accumulator
`timescale 1ns/1ps

module spa_accum_asserts (
  input wire ref_clk_i, // Clock
  input wire rst_b_i, // Reset, active low
  input wire rx_valid_i, // Byte offered
  input wire rx_ready_o, // Byte taken
  input wire [7:0] rx_data_i, // Byte
  input wire tx_valid_o, // Packet byte ready
  input wire tx_ready_i, // Network takes
  input wire [7:0] tx_data_o, // Packet byte
  input wire tx_last_o, // Final byte
  input wire [10:0] pkt_len_i, // Length
  input wire delim1_en_i, // First enable
  input wire [7:0] delim1_i, // First char
  input wire delim2_en_i, // Second enable
  input wire [7:0] delim2_i, // Second char
  input wire [1:0] delim_proc_i, // Process
  input wire link_down_low_i, // Option
  input wire link_up_i, // Link state
  input wire rts_req_i, // Requested RTS
  input wire dtr_req_i, // Requested DTR
  input wire rts_o, // RTS
  input wire dtr_o, // DTR
  input wire busy_o // Draining
);
  reg [10:0] acc_q;
  wire take = rx_valid_i && rx_ready_o;
  // Modem levels the rules call for, one cycle before the outputs
  wire rts_want = rts_req_i && !(link_down_low_i && !link_up_i);
  wire dtr_want = dtr_req_i && !(link_down_low_i && !link_up_i);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  // ==========================================================
  // Bytes held since the last drain; cleared while refusing
  always @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      acc_q <= 11'h000;
    else if (!rx_ready_o)
      acc_q <= 11'h000;
    else if (rx_valid_i)
      acc_q <= acc_q + 11'h001;

  a_len_release: assert property (take && pkt_len_i != 11'h000 &&
    acc_q + 11'h001 == pkt_len_i |=> busy_o) else $error("no length release");
  a_full_release: assert property (take && acc_q == 11'h3ff
    |=> busy_o) else $error("no release on full buffer");
  a_delim_single: assert property (take && delim1_en_i && !delim2_en_i &&
    pkt_len_i == 11'h000 && delim_proc_i == 2'h0 && rx_data_i == delim1_i
    |=> busy_o) else $error("no release on delimiter");
  a_hold_nolimit: assert property (take && pkt_len_i == 11'h000 &&
    !delim1_en_i && acc_q < 11'h3ff |=> !busy_o) else $error("early release");
  a_dual_wait: assert property (take && delim1_en_i && delim2_en_i &&
    pkt_len_i == 11'h000 && delim_proc_i == 2'h0 &&
    rx_data_i != delim2_i && acc_q < 11'h3ff
    |=> !busy_o) else $error("release without both delimiters");
  a_drain_start: assert property ($rose(busy_o) |-> !rx_ready_o
    ##1 tx_valid_o) else $error("drain start wrong");
  a_stall_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
    && $stable(tx_data_o) && $stable(tx_last_o)) else $error("byte lost");
  a_rts_link: assert property ($past(rst_b_i) |-> rts_o ==
    $past(rts_want)) else $error("rts");
  a_dtr_link: assert property ($past(rst_b_i) |-> dtr_o ==
    $past(dtr_want)) else $error("dtr");
endmodule // spa_accum_asserts

bind spa_accum spa_accum_asserts chk (.ref_clk_i(ref_clk_i),
  .rst_b_i(rst_b_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
  .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
  .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .pkt_len_i(pkt_len_i),
  .delim1_en_i(delim1_en_i), .delim1_i(delim1_i), .delim2_i(delim2_i),
  .delim2_en_i(delim2_en_i), .delim_proc_i(delim_proc_i),
  .link_down_low_i(link_down_low_i), .link_up_i(link_up_i),
  .rts_req_i(rts_req_i), .dtr_req_i(dtr_req_i), .rts_o(rts_o),
  .dtr_o(dtr_o), .busy_o(busy_o));

// file: spa_net_model.sv
// Network side sink that collects packet bytes, with optional stalls
`timescale 1ns/1ps

module spa_net_model (
  input wire ref_clk_i, // Clock
  input wire rst_b_i, // Reset, active low
  input wire slow_i, // Stall three cycles of four
  input wire tx_valid_i, // Byte offered
  input wire [7:0] tx_data_i, // Byte
  input wire tx_last_i, // Final byte
  output reg tx_ready_o = 1'b0 // Byte taken
);
  logic [7:0] got[$];
  int lasts = 0;
  int ph = 0;

  // ==========================================================
  // Take at the edge, then move ready just after it, never on it
  always @(posedge ref_clk_i)
  begin
    if (rst_b_i && tx_valid_i && tx_ready_o)
    begin
      got.push_back(tx_data_i);
      if (tx_last_i)
        lasts++;
    end
    ph++;
    #1 tx_ready_o = rst_b_i && (!slow_i || ph % 4 == 0);
  end
endmodule // spa_net_model

// file: serial_packet_accumulator_tb.sv
// Self-checking bench for the serial packet accumulator
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin \
  bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end

module serial_packet_accumulator_tb;
  reg ref_clk_i = 1'b0, rst_b_i = 1'b0, rx_valid_i = 1'b0, slow = 1'b0;
  reg e1 = 1'b0, e2 = 1'b0, ldl = 1'b0, up = 1'b1, rts_r = 1'b0;
  reg dtr_r = 1'b0;
  reg [7:0] rx_data_i = 8'h00, d1 = 8'h0d, d2 = 8'h0a;
  reg [10:0] pkt_len = 11'h000;
  reg [1:0] dproc = 2'h0;
  reg [15:0] gap = 16'h0000;
  wire rx_ready, tx_valid, tx_ready, tx_last, rts, dtr, busy;
  wire [7:0] tx_data;
  int bad_count = 0, samples_checked = 0;
  logic [7:0] exp_q[$];

  // Short millisecond keeps the gap scenario brief
  spa_accum #(.MS_CYCLES(10)) uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready), .rx_data_i(rx_data_i),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_data_o(tx_data),
    .tx_last_o(tx_last), .pkt_len_i(pkt_len), .delim1_en_i(e1),
    .delim1_i(d1), .delim2_en_i(e2), .delim2_i(d2), .delim_proc_i(dproc),
    .gap_ms_i(gap), .link_down_low_i(ldl), .link_up_i(up), .rts_o(rts),
    .rts_req_i(rts_r), .dtr_req_i(dtr_r), .dtr_o(dtr), .busy_o(busy));
  spa_net_model net (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .slow_i(slow),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last),
    .tx_ready_o(tx_ready));

  initial
  begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================
  // Shared tasks
  task results;
  begin
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  // Bytes go back to back; valid holds until an edge sees ready
  task tx_bytes(input logic [7:0] b[$]);
    int n;
  begin
    foreach (b[i])
    begin
      n = 0;
      rx_valid_i = 1'b1;
      rx_data_i = b[i];
      while (!rx_ready && n < 5000)
      begin
        @(posedge ref_clk_i);
        #1;
        n++;
      end
      if (n == 5000)
      begin
        bad_count++;
        results;
      end
      @(posedge ref_clk_i);
      #1;
    end
    rx_valid_i = 1'b0;
  end
  endtask

  task quiet(input int c);
  begin
    repeat (c) @(posedge ref_clk_i);
    #1;
    `CHK("early", 0, net.lasts)
  end
  endtask

  task expect_pkts(input int k);
    int n;
  begin
    n = 0;
    while (net.lasts < k && n < 20000)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (n == 20000)
    begin
      bad_count++;
      results;
    end
    repeat (3) @(posedge ref_clk_i);
    #1;
    `CHK("packets", k, net.lasts)
    `CHK("length", exp_q.size(), net.got.size())
    foreach (exp_q[i])
      if (i < net.got.size())
        `CHK("byte", exp_q[i], net.got[i])
    exp_q.delete();
    net.got.delete();
    net.lasts = 0;
  end
  endtask

  // ==========================================================
  // Scenarios
  task s_len;
  begin
    pkt_len = 11'h003;
    slow = 1'b1;
    exp_q = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
    tx_bytes(exp_q);
    expect_pkts(2);
    pkt_len = 11'h000;
  end
  endtask

  // length zero before any delimiter is enabled
  task s_delim;
    int p;
  begin
    e1 = 1'b1;
    for (p = 0; p < 4; p++)
    begin
      dproc = p[1:0];
      exp_q = '{8'h11, 8'h22};
      if (p != 3)
        exp_q.push_back(d1);
      tx_bytes('{8'h11, 8'h22, d1});
      repeat (p % 3)
      begin
        quiet(40);
        exp_q.push_back(8'h33);
        tx_bytes('{8'h33});
      end
      expect_pkts(1);
    end
  end
  endtask

  // second delimiter only together with the first
  task s_dual;
    int p;
  begin
    e2 = 1'b1;
    for (p = 0; p < 4; p = p + 3)
    begin
      dproc = p[1:0];
      // Strip of a lone pair only empties the buffer, no packet
      if (p == 3)
        tx_bytes('{d1, d2});
      exp_q = '{8'h11, d1, 8'h22, d1, d2};
      if (p == 3)
        exp_q = '{8'h11, d1, 8'h22};
      tx_bytes('{8'h11, d1, 8'h22, d1, d2});
      expect_pkts(1);
    end
    e2 = 1'b0;
  end
  endtask

  // a full buffer of data, stalled on the far side
  task s_full;
    int i;
  begin
    for (i = 0; i < 1024; i++)
      exp_q.push_back(i[7:0] & 8'h07);
    tx_bytes(exp_q);
    expect_pkts(1);
    slow = 1'b0;
  end
  endtask

  // two milliseconds is far above one character time
  task s_gap;
  begin
    e1 = 1'b0;
    dproc = 2'h3;
    gap = 16'h0002;
    exp_q = '{8'h11, d1, 8'h22};
    tx_bytes(exp_q);
    quiet(28);
    expect_pkts(1);
    gap = 16'h0000;
  end
  endtask

  task s_modem;
    int i;
  begin
    for (i = 0; i < 8; i++)
    begin
      {ldl, up, rts_r} = i[2:0];
      dtr_r = ~i[0];
      repeat (2) @(posedge ref_clk_i);
      #1;
      `CHK("rts", i[0] && !(i[2] && !i[1]), rts)
      `CHK("dtr", !i[0] && !(i[2] && !i[1]), dtr)
    end
  end
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b1;
    s_len;
    s_delim;
    s_dual;
    s_full;
    s_gap;
    s_modem;
    results;
  end
endmodule // serial_packet_accumulator_tb
